// File: rtl/ldp_panel.sv
`timescale 1ns/10ps
module ldp_panel (
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic                     prim_level,
    input  wire logic                     prim_delay_run,
    input  wire logic                     prim_ext_run,
    input  wire logic                     prim_check_fail,
    input  wire logic                     aux_level,
    input  wire logic                     aux_check_fail,
    input  wire logic [1:0]               synch_option,
    input  wire logic                     sample_done,
    input  wire logic [ldp_pkg::N_CH-1:0] loop_low_fault,
    input  wire logic [ldp_pkg::N_CH-1:0] loop_high_fault,
    input  wire logic [ldp_pkg::N_CH-1:0] loop_call,
    input  wire logic [ldp_pkg::N_CH-1:0] channel_button_reset,
    input  wire logic [4*ldp_pkg::N_CH-1:0] bar_level,
    input  wire logic [3:0]               sens_level,
    input  wire logic                     param_mismatch,
    input  wire logic                     function_button,
    input  wire logic                     channel_button,
    input  wire logic                     up_button,
    input  wire logic                     down_button,
    output logic                          prim_out,
    output logic [1:0]                    prim_led,
    output logic [1:0]                    aux_led,
    output logic [ldp_pkg::N_CH-1:0]      channel_button_call,
    output logic [ldp_pkg::N_CH-1:0]      channel_button_led,
    output logic [3:0]                    disp_code,
    output logic [ldp_pkg::CNT_W-1:0]     disp_value,
    output logic [1:0]                    disp_channel_button,
    output logic [ldp_pkg::BAR_W-1:0]     bargraph,
    output logic                          disp_test,
    output logic                          factory_restore,
    output logic                          diag_active,
    output logic [ldp_pkg::N_CH-1:0]      audible_en,
    output logic                          copy_inward,
    output logic                          copy_outward
);
    ldp_tick_if tk ();

    ldp_blink u_blink (
        .mclk   (mclk),
        .arst_n (arst_n),
        .tk     (tk)
    );

    typedef enum logic [1:0] {ST_NORMAL, ST_RESTORE, ST_COPY_IN, ST_COPY_OUT} ldp_mode_t;

    typedef struct packed {
        ldp_mode_t                         mode;
        logic [3:0]                        btn_q;
        logic [ldp_pkg::N_CH-1:0]          fail_q;
        logic [ldp_pkg::N_CH-1:0]          latch;
        logic                              synch_fail;
        logic [1:0]                        sel;
        logic [3:0]                        screen;
        logic [12:0]                       hold_ms;
        logic [19:0]                       diag_ms;
        logic                              diag;
        logic                              prim_out;
        logic [1:0]                        prim_led;
        logic [1:0]                        aux_led;
        logic [ldp_pkg::N_CH-1:0]          call;
        logic [ldp_pkg::N_CH-1:0]          led;
        logic [3:0]                        code;
        logic [ldp_pkg::CNT_W-1:0]         value;
        logic [ldp_pkg::BAR_W-1:0]         bar;
        logic                              test;
        logic                              restore;
        logic [ldp_pkg::N_CH-1:0]          aud;
        logic                              cin;
        logic                              cout;
    } ldp_state_t;
    ldp_state_t s, next_s;

    logic [3:0]                    btn;
    logic [3:0]                    press;
    logic [ldp_pkg::N_CH-1:0]      fail_now;
    logic [ldp_pkg::N_CH-1:0]      fail_rise;
    logic [ldp_pkg::N_CH-1:0]      cnt_clr;
    logic [ldp_pkg::CNT_W-1:0]     cnt_rd;
    logic [2:0]                    nbtn;
    logic                          on_count;

    function automatic logic [ldp_pkg::BAR_W-1:0] bar_fill(input logic [3:0] lvl,
                                                           input logic [3:0] sens);
        logic [4:0] n;
        n = 5'h00;
        bar_fill = '0;
        if (lvl != 4'h0 && lvl <= sens) begin
            n = {1'b0, sens} - {1'b0, lvl} + 5'h01;
            for (int k = 0; k < ldp_pkg::BAR_W; k++)
                bar_fill[k] = (5'(k) < n);
        end
    endfunction

    assign btn       = {function_button, channel_button, up_button, down_button};
    assign press     = btn & ~s.btn_q;
    assign nbtn      = 3'(btn[0]) + 3'(btn[1]) + 3'(btn[2]) + 3'(btn[3]);
    assign fail_now  = loop_low_fault | loop_high_fault;
    assign fail_rise = fail_now & ~s.fail_q;
    assign on_count  = (s.screen == ldp_pkg::N_OPTION_SCREENS + 4'h1);
    assign cnt_clr   = channel_button_reset | (((press[1] | press[0]) && on_count
                       && s.mode == ST_NORMAL && nbtn == 3'h1) ? (4'h1 << s.sel) : 4'h0);

    ldp_fail_mem u_mem (
        .mclk      (mclk),
        .arst_n    (arst_n),
        .fail_rise (fail_rise),
        .clr       (cnt_clr),
        .rd_ch     (s.sel),
        .rd_data   (cnt_rd)
    );

    always_comb begin
        next_s = s;
        next_s.btn_q   = btn;
        next_s.fail_q  = fail_now;
        next_s.restore = 1'b0;
        next_s.cin     = 1'b0;
        next_s.cout    = 1'b0;

        // Primary and auxiliary indicators
        next_s.prim_out = prim_level && !prim_delay_run && !prim_ext_run;
        if (prim_check_fail)
            next_s.prim_led = ldp_pkg::LED_RED;
        else if (prim_delay_run)
            next_s.prim_led = tk.ph_delay ? ldp_pkg::LED_GREEN : ldp_pkg::LED_OFF;
        else if (prim_ext_run)
            next_s.prim_led = tk.ph_ext ? ldp_pkg::LED_GREEN : ldp_pkg::LED_OFF;
        else
            next_s.prim_led = prim_level ? ldp_pkg::LED_GREEN : ldp_pkg::LED_OFF;
        next_s.aux_led = aux_check_fail ? ldp_pkg::LED_RED :
                         (aux_level ? ldp_pkg::LED_GREEN : ldp_pkg::LED_OFF);

        // Loop failure handling per channel
        for (int i = 0; i < ldp_pkg::N_CH; i++) begin
            if (fail_rise[i])
                next_s.latch[i] = 1'b1;
            else if (channel_button_reset[i])
                next_s.latch[i] = 1'b0;
            next_s.call[i] = fail_now[i] | loop_call[i];
            next_s.led[i]  = s.latch[i] ? tk.ph_fail : loop_call[i];
        end

        // Synch failure evaluated once per sampling pass
        if (sample_done)
            next_s.synch_fail = |fail_now;

        // Diagnostic timer
        if (s.diag_ms != 20'h0 && tk.ms_tick)
            next_s.diag_ms = s.diag_ms - 20'h1;

        case (s.mode)
            ST_NORMAL: begin
                if (param_mismatch) begin
                    next_s.mode = ST_COPY_IN;
                end else if (nbtn == 3'h4) begin
                    next_s.mode    = ST_RESTORE;
                    next_s.hold_ms = 13'(ldp_pkg::RESTORE_MS);
                end else if (nbtn == 3'h1) begin
                    if (press[2]) begin
                        next_s.sel    = s.sel + 2'h1;
                        next_s.screen = 4'h0;
                    end
                    if (press[3])
                        next_s.screen = on_count ? 4'h0 : s.screen + 4'h1;
                    if ((press[1] | press[0]) && s.screen == 4'h0) begin
                        next_s.diag_ms = 20'(ldp_pkg::DIAG_MS);
                        next_s.aud     = 4'h1 << s.sel;
                    end
                end
            end
            ST_RESTORE: begin
                if (nbtn != 3'h4) begin
                    next_s.mode = ST_NORMAL;
                end else if (tk.ms_tick) begin
                    if (s.hold_ms == 13'h1) begin
                        next_s.mode    = ST_NORMAL;
                        next_s.restore = 1'b1;
                        next_s.diag_ms = 20'h0;
                        next_s.screen  = 4'h0;
                    end else begin
                        next_s.hold_ms = s.hold_ms - 13'h1;
                    end
                end
            end
            ST_COPY_IN: begin
                if (press[3]) begin
                    next_s.mode = ST_NORMAL;
                    next_s.cin  = 1'b1;
                end else if (press[1] | press[0]) begin
                    next_s.mode = ST_COPY_OUT;
                end
            end
            ST_COPY_OUT: begin
                if (press[3]) begin
                    next_s.mode = ST_NORMAL;
                    next_s.cout = 1'b1;
                end
            end
            default: next_s.mode = ST_NORMAL;
        endcase

        if (next_s.diag_ms == 20'h0)
            next_s.aud = 4'h0;
        next_s.diag = (next_s.diag_ms != 20'h0);

        // Display selection
        next_s.test  = (nbtn == 3'h2 || nbtn == 3'h3);
        next_s.value = '0;
        next_s.bar   = bar_fill(bar_level[s.sel*4 +: 4], sens_level);
        if (s.mode == ST_COPY_IN)
            next_s.code = tk.ph_alt ? ldp_pkg::DISP_COPY_WORD : ldp_pkg::DISP_COPY_IN;
        else if (s.mode == ST_COPY_OUT)
            next_s.code = tk.ph_alt ? ldp_pkg::DISP_COPY_WORD : ldp_pkg::DISP_COPY_OUT;
        else if (s.mode == ST_RESTORE) begin
            next_s.code  = ldp_pkg::DISP_COUNTDOWN;
            next_s.value = 8'((s.hold_ms + 13'd999) / 13'd1000);
        end else if (on_count) begin
            next_s.code  = ldp_pkg::DISP_FAIL_COUNT;
            next_s.value = cnt_rd;
        end else if (s.screen != 4'h0)
            next_s.code = ldp_pkg::DISP_OPTION;
        else if (loop_low_fault[s.sel])
            next_s.code = ldp_pkg::DISP_LOOP_FAIL_LOW;
        else if (loop_high_fault[s.sel])
            next_s.code = ldp_pkg::DISP_HIGH_FAULT;
        else if (s.synch_fail && (synch_option == ldp_pkg::SYNCH_SERIES
                 || synch_option == ldp_pkg::SYNCH_PARALLEL))
            next_s.code = ldp_pkg::DISP_SYNCH_FAILURE;
        else if (synch_option == ldp_pkg::SYNCH_SERIES)
            next_s.code = ldp_pkg::DISP_SERIES_SYNCH;
        else if (synch_option == ldp_pkg::SYNCH_PARALLEL)
            next_s.code = ldp_pkg::DISP_PARALLEL_SYNCH;
        else
            next_s.code = ldp_pkg::DISP_BLANK;
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) s <= '0;
        else s <= next_s;
    end

    assign prim_out        = s.prim_out;
    assign prim_led        = s.prim_led;
    assign aux_led         = s.aux_led;
    assign channel_button_call       = s.call;
    assign channel_button_led        = s.led;
    assign disp_code       = s.code;
    assign disp_value      = s.value;
    assign disp_channel_button       = s.sel;
    assign bargraph        = s.bar;
    assign disp_test       = s.test;
    assign factory_restore = s.restore;
    assign diag_active     = s.diag;
    assign audible_en      = s.aud;
    assign copy_inward     = s.cin;
    assign copy_outward    = s.cout;

    property p_prim_red;
        @(posedge mclk) disable iff (!arst_n) prim_check_fail |=> prim_led == ldp_pkg::LED_RED;
    endproperty
    a_prim_red: assert property (p_prim_red) else $error("primary red missing");
    property p_delay_low;
        @(posedge mclk) disable iff (!arst_n) prim_delay_run |=> !prim_out;
    endproperty
    a_delay_low: assert property (p_delay_low) else $error("output high in delay");
    property p_aux;
        @(posedge mclk) disable iff (!arst_n)
            (!aux_check_fail && aux_level) |=> aux_led == ldp_pkg::LED_GREEN;
    endproperty
    a_aux: assert property (p_aux) else $error("aux led not green");
    property p_call;
        @(posedge mclk) disable iff (!arst_n) |fail_now |=> |channel_button_call;
    endproperty
    a_call: assert property (p_call) else $error("no fail-safe call");
    property p_latch;
        @(posedge mclk) disable iff (!arst_n)
            (fail_rise[0] && !channel_button_reset[0]) |=> s.latch[0];
    endproperty
    a_latch: assert property (p_latch) else $error("fail latch lost");
    property p_test;
        @(posedge mclk) disable iff (!arst_n) (nbtn == 3'h2) |=> disp_test;
    endproperty
    a_test: assert property (p_test) else $error("display test missing");
    property p_abort;
        @(posedge mclk) disable iff (!arst_n)
            (s.mode == ST_RESTORE && nbtn != 3'h4) |=> !factory_restore && s.mode == ST_NORMAL;
    endproperty
    a_abort: assert property (p_abort) else $error("restore not aborted");
    property p_copy_in;
        @(posedge mclk) disable iff (!arst_n)
            (s.mode == ST_COPY_IN && press[3]) |=> copy_inward && !copy_outward;
    endproperty
    a_copy_in: assert property (p_copy_in) else $error("copy inward missing");
    property p_sync_series;
        @(posedge mclk) disable iff (!arst_n)
            (s.mode == ST_NORMAL && s.screen == 4'h0 && fail_now == 4'h0 && !s.synch_fail
             && synch_option == ldp_pkg::SYNCH_SERIES && !param_mismatch && nbtn == 3'h0)
            |=> disp_code == ldp_pkg::DISP_SERIES_SYNCH;
    endproperty
    a_sync_series: assert property (p_sync_series) else $error("series code missing");

    c_restore: cover property (@(posedge mclk) disable iff (!arst_n) factory_restore);
    c_copy_out: cover property (@(posedge mclk) disable iff (!arst_n) copy_outward);
    c_fail: cover property (@(posedge mclk) disable iff (!arst_n) |fail_rise);
endmodule

// File: rtl/ldp_pkg.sv
package ldp_pkg;
    localparam int  CLK_HZ        = 40000000;
    localparam int  N_CH          = 4;
    localparam int  CNT_W         = 8;
    localparam int  BAR_W         = 8;
    // Display codes on the message field
    localparam logic [3:0] DISP_BLANK          = 4'h0;
    localparam logic [3:0] DISP_SERIES_SYNCH   = 4'h1;
    localparam logic [3:0] DISP_PARALLEL_SYNCH = 4'h2;
    localparam logic [3:0] DISP_SYNCH_FAILURE  = 4'h3;
    localparam logic [3:0] DISP_LOOP_FAIL_LOW  = 4'h4;
    localparam logic [3:0] DISP_HIGH_FAULT     = 4'h5;
    localparam logic [3:0] DISP_FAIL_COUNT     = 4'h6;
    localparam logic [3:0] DISP_COUNTDOWN      = 4'h7;
    localparam logic [3:0] DISP_COPY_IN        = 4'h8;
    localparam logic [3:0] DISP_COPY_OUT       = 4'h9;
    localparam logic [3:0] DISP_OPTION         = 4'ha;
    localparam logic [3:0] DISP_COPY_WORD      = 4'hb;
    // Synch option values
    localparam logic [1:0] SYNCH_SERIES   = 2'h1;
    localparam logic [1:0] SYNCH_PARALLEL = 2'h2;
    // Function-sequence screens
    localparam logic [3:0] N_OPTION_SCREENS = 4'h7;
    // Blink rates in Hz and timing constants, with derived half periods in ms
    localparam int  DELAY_HZ       = 2;
    localparam int  EXT_HZ         = 5;
    localparam int  FAIL_HZ        = 3;
    localparam int  MS_CYC         = CLK_HZ / 1000;
    localparam int  RESTORE_S      = 5;
    localparam int  DIAG_MIN       = 15;
    localparam int  ALT_MS         = 500;
    localparam int  DELAY_HALF_MS  = 1000 / (2 * DELAY_HZ);
    localparam int  EXT_HALF_MS    = 1000 / (2 * EXT_HZ);
    localparam int  FAIL_HALF_MS   = 1000 / (2 * FAIL_HZ);
    localparam int  RESTORE_MS     = RESTORE_S * 1000;
    localparam int  DIAG_MS        = DIAG_MIN * 60 * 1000;
    // Indicator colours
    localparam logic [1:0] LED_OFF   = 2'h0;
    localparam logic [1:0] LED_GREEN = 2'h1;
    localparam logic [1:0] LED_RED   = 2'h2;
endpackage

// File: rtl/ldp_tick_if.sv
`timescale 1ns/10ps
interface ldp_tick_if;
    logic ms_tick;
    logic ph_delay;
    logic ph_ext;
    logic ph_fail;
    logic ph_alt;
    modport src (output ms_tick, output ph_delay, output ph_ext, output ph_fail, output ph_alt);
    modport dst (input ms_tick, input ph_delay, input ph_ext, input ph_fail, input ph_alt);
endinterface

// File: rtl/ldp_blink.sv
`timescale 1ns/10ps
module ldp_blink (
    input  wire logic mclk,
    input  wire logic arst_n,
    ldp_tick_if.src   tk
);
    typedef struct packed {
        logic [15:0] pre;
        logic        ms;
        logic [9:0]  cd;
        logic [9:0]  ce;
        logic [9:0]  cf;
        logic [9:0]  ca;
        logic        pd;
        logic        pe;
        logic        pf;
        logic        pa;
    } ldp_blink_t;
    ldp_blink_t s, next_s;

    function automatic logic [9:0] step(input logic [9:0] c, input int half);
        step = (c >= 10'(half - 1)) ? 10'h000 : c + 10'h001;
    endfunction

    always_comb begin
        next_s = s;
        next_s.ms = (s.pre == 16'(ldp_pkg::MS_CYC - 1));
        next_s.pre = next_s.ms ? 16'h0000 : s.pre + 16'h0001;
        if (s.ms) begin
            next_s.cd = step(s.cd, ldp_pkg::DELAY_HALF_MS);
            next_s.ce = step(s.ce, ldp_pkg::EXT_HALF_MS);
            next_s.cf = step(s.cf, ldp_pkg::FAIL_HALF_MS);
            next_s.ca = step(s.ca, ldp_pkg::ALT_MS);
            if (next_s.cd == 10'h000) next_s.pd = ~s.pd;
            if (next_s.ce == 10'h000) next_s.pe = ~s.pe;
            if (next_s.cf == 10'h000) next_s.pf = ~s.pf;
            if (next_s.ca == 10'h000) next_s.pa = ~s.pa;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) s <= '0;
        else s <= next_s;
    end

    assign tk.ms_tick  = s.ms;
    assign tk.ph_delay = s.pd;
    assign tk.ph_ext   = s.pe;
    assign tk.ph_fail  = s.pf;
    assign tk.ph_alt   = s.pa;
endmodule

// File: rtl/ldp_fail_mem.sv
`timescale 1ns/10ps
module ldp_fail_mem (
    input  wire logic                      mclk,
    input  wire logic                      arst_n,
    input  wire logic [ldp_pkg::N_CH-1:0]  fail_rise,
    input  wire logic [ldp_pkg::N_CH-1:0]  clr,
    input  wire logic [1:0]                rd_ch,
    output logic [ldp_pkg::CNT_W-1:0]      rd_data
);
    typedef struct packed {
        logic [ldp_pkg::N_CH-1:0][ldp_pkg::CNT_W-1:0] cnt;
        logic [ldp_pkg::CNT_W-1:0]                    rd;
    } ldp_mem_t;
    ldp_mem_t s, next_s;

    always_comb begin
        next_s = s;
        for (int i = 0; i < ldp_pkg::N_CH; i++) begin
            if (fail_rise[i] && s.cnt[i] != '1)
                next_s.cnt[i] = s.cnt[i] + 8'h01;
            else if (clr[i])
                next_s.cnt[i] = '0;
        end
        next_s.rd = s.cnt[rd_ch];
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) s <= '0;
        else s <= next_s;
    end

    assign rd_data = s.rd;
endmodule

// File: tb/ldp_loop_model.sv
`timescale 1ns/10ps
module ldp_loop_model (
    input  wire logic                     mclk,
    input  wire logic                     arst_n,
    input  wire logic [1:0]               fault_ch,
    input  wire logic [1:0]               fault_kind,
    output logic [ldp_pkg::N_CH-1:0]      loop_low_fault,
    output logic [ldp_pkg::N_CH-1:0]      loop_high_fault,
    output logic [ldp_pkg::N_CH-1:0]      loop_call
);
    // Kind 1 shorted loop, 2 open loop, 3 vehicle present, 0 healthy
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            loop_low_fault  <= 4'h0;
            loop_high_fault <= 4'h0;
            loop_call       <= 4'h0;
        end else begin
            loop_low_fault  <= (fault_kind == 2'h1) ? (4'h1 << fault_ch) : 4'h0;
            loop_high_fault <= (fault_kind == 2'h2) ? (4'h1 << fault_ch) : 4'h0;
            loop_call       <= (fault_kind == 2'h3) ? (4'h1 << fault_ch) : 4'h0;
        end
    end
endmodule

// File: tb/ldp_panel_bench.sv
`timescale 1ns/10ps
module ldp_panel_bench;
    logic mclk = 1'b0, arst_n = 1'b0;
    logic prim_level = 0, prim_delay_run = 0, prim_ext_run = 0, prim_check_fail = 0;
    logic aux_level = 0, aux_check_fail = 0, sample_done = 0, param_mismatch = 0;
    logic [1:0] synch_option = 2'h0, fault_ch = 2'h0, fault_kind = 2'h0;
    logic [3:0] channel_button_reset = 4'h0, btn = 4'h0, low_f, high_f, call_f;
    logic [15:0] bar_lvl = 16'h0000;
    logic [3:0] sens = 4'h5;
    logic prim_out, disp_test, factory_restore, diag_active, copy_inward, copy_outward;
    logic [1:0] prim_led, aux_led, disp_channel_button;
    logic [3:0] channel_button_call, channel_button_led, disp_code, audible_en;
    logic [7:0] disp_value, bargraph;
    int fail_count = 0, n_compared = 0, k;
    always #12.5 mclk = ~mclk;
    ldp_loop_model ldp_loop_model_i (.mclk(mclk), .arst_n(arst_n), .fault_ch(fault_ch),
        .fault_kind(fault_kind), .loop_low_fault(low_f), .loop_high_fault(high_f),
        .loop_call(call_f));
    ldp_panel ldp_panel_i (.mclk(mclk), .arst_n(arst_n), .prim_level(prim_level),
        .prim_delay_run(prim_delay_run), .prim_ext_run(prim_ext_run),
        .prim_check_fail(prim_check_fail), .aux_level(aux_level),
        .aux_check_fail(aux_check_fail), .synch_option(synch_option),
        .sample_done(sample_done), .loop_low_fault(low_f), .loop_high_fault(high_f),
        .loop_call(call_f), .channel_button_reset(channel_button_reset), .bar_level(bar_lvl),
        .sens_level(sens), .param_mismatch(param_mismatch), .function_button(btn[3]),
        .channel_button(btn[2]), .up_button(btn[1]), .down_button(btn[0]),
        .prim_out(prim_out), .prim_led(prim_led), .aux_led(aux_led), .channel_button_call(channel_button_call),
        .channel_button_led(channel_button_led), .disp_code(disp_code), .disp_value(disp_value),
        .disp_channel_button(disp_channel_button), .bargraph(bargraph), .disp_test(disp_test),
        .factory_restore(factory_restore), .diag_active(diag_active),
        .audible_en(audible_en), .copy_inward(copy_inward), .copy_outward(copy_outward));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test();
        if (fail_count == 0 && n_compared > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask
    // Holds a button pattern for three cycles, then releases it
    task automatic press(input logic [3:0] b);
        @(posedge mclk);
        btn <= b;
        settle(2);
        @(posedge mclk);
        btn <= 4'h0;
        settle(2);
    endtask
    // Bounded wait for a one-cycle pulse; sel 0 inward, 1 outward
    task automatic catch_pulse(input bit sel, input logic [3:0] b);
        logic got;
        got = 1'b0;
        @(posedge mclk);
        btn <= b;
        for (int i = 0; i < 8; i++) begin
            @(posedge mclk);
            #1;
            got = got | (sel ? copy_outward : copy_inward);
        end
        @(posedge mclk);
        btn <= 4'h0;
        check({7'h0, got}, 8'h01);
    endtask
    function automatic logic [1:0] aux_expect(input logic lvl, input logic bad);
        return bad ? ldp_pkg::LED_RED : (lvl ? ldp_pkg::LED_GREEN : ldp_pkg::LED_OFF);
    endfunction
    // One segment per threshold from the set level down to the exceeded one
    function automatic logic [7:0] bar_expect(input logic [3:0] lvl, input logic [3:0] sv);
        for (int j = 0; j < 8; j++)
            bar_expect[j] = (lvl != 4'h0 && lvl <= sv && j <= int'(sv) - int'(lvl));
    endfunction
    // Applies a loop condition, lets it reach the panel, then ends one sampling pass
    task automatic fault_pass(input logic [1:0] ch, input logic [1:0] kind);
        @(posedge mclk);
        fault_ch <= ch;
        fault_kind <= kind;
        settle(2);
        @(posedge mclk);
        sample_done <= 1'b1;
        @(posedge mclk);
        sample_done <= 1'b0;
        settle(3);
    endtask

    initial begin
        void'($urandom(32'h1b3a2364));
        repeat (12) @(posedge mclk);
        arst_n <= 1'b1;
        @(posedge mclk);
        prim_level <= 1'b1;
        settle(3);
        check({6'h0, prim_led}, {6'h0, ldp_pkg::LED_GREEN});
        check({7'h0, prim_out}, 8'h01);
        @(posedge mclk);
        prim_delay_run <= 1'b1;
        settle(3);
        check({7'h0, prim_out}, 8'h00);
        @(posedge mclk);
        prim_delay_run <= 1'b0;
        prim_ext_run <= 1'b1;
        settle(3);
        check({7'h0, prim_out}, 8'h00);
        @(posedge mclk);
        prim_ext_run <= 1'b0;
        prim_level <= 1'b0;
        settle(3);
        check({6'h0, prim_led}, {6'h0, ldp_pkg::LED_OFF});
        @(posedge mclk);
        prim_check_fail <= 1'b1;
        settle(3);
        check({6'h0, prim_led}, {6'h0, ldp_pkg::LED_RED});
        for (k = 0; k < 8; k++) begin
            @(posedge mclk);
            aux_level <= 1'($urandom);
            aux_check_fail <= (k == 5);
            settle(3);
            check({6'h0, aux_led}, {6'h0, aux_expect(aux_level, aux_check_fail)});
        end
        for (k = 0; k < 6; k++) begin
            @(posedge mclk);
            bar_lvl <= (k == 0) ? 16'h0003 : {12'h000, 4'($urandom_range(0, 8))};
            sens <= (k == 0) ? 4'h8 : 4'($urandom_range(1, 8));
            settle(3);
            check(bargraph, bar_expect(bar_lvl[3:0], sens));
        end
        @(posedge mclk);
        synch_option <= ldp_pkg::SYNCH_SERIES;
        settle(3);
        check({4'h0, disp_code}, {4'h0, ldp_pkg::DISP_SERIES_SYNCH});
        @(posedge mclk);
        synch_option <= ldp_pkg::SYNCH_PARALLEL;
        fault_pass(2'($urandom_range(1, 3)), 2'($urandom_range(1, 2)));
        check({4'h0, disp_code}, {4'h0, ldp_pkg::DISP_SYNCH_FAILURE});
        check({4'h0, channel_button_call}, {4'h0, 4'h1 << fault_ch});
        fault_pass(2'h0, 2'h1);
        check({4'h0, disp_code}, {4'h0, ldp_pkg::DISP_LOOP_FAIL_LOW});
        fault_pass(2'h0, 2'h2);
        check({4'h0, disp_code}, {4'h0, ldp_pkg::DISP_HIGH_FAULT});
        check({4'h0, channel_button_call}, 8'h01);
        fault_pass(2'h0, 2'h0);
        check({4'h0, disp_code}, {4'h0, ldp_pkg::DISP_PARALLEL_SYNCH});
        check({4'h0, channel_button_call}, 8'h00);
        @(posedge mclk);
        btn <= 4'hf;
        settle(3);
        check({4'h0, disp_code}, {4'h0, ldp_pkg::DISP_COUNTDOWN});
        check(disp_value, 8'(ldp_pkg::RESTORE_S));
        @(posedge mclk);
        btn <= 4'h0;
        settle(3);
        check({7'h0, factory_restore}, 8'h00);
        check({4'h0, disp_code}, {4'h0, ldp_pkg::DISP_PARALLEL_SYNCH});
        repeat (8) press(4'h8);
        check({4'h0, disp_code}, {4'h0, ldp_pkg::DISP_FAIL_COUNT});
        check(disp_value, 8'h01);
        press(4'h2);
        check(disp_value, 8'h00);
        press(4'h4);
        check({6'h0, disp_channel_button}, 8'h01);
        press(4'h2);
        check({7'h0, diag_active}, 8'h01);
        check({4'h0, audible_en}, 8'h02);
        @(posedge mclk);
        synch_option <= 2'h0;
        btn <= 4'h6;
        settle(3);
        check({7'h0, disp_test}, 8'h01);
        @(posedge mclk);
        btn <= 4'h0;
        param_mismatch <= 1'b1;
        settle(3);
        catch_pulse(1'b0, 4'h8);
        settle(2);
        press(4'h2);
        catch_pulse(1'b1, 4'h8);
        finish_test();
    end
    initial begin
        #1ms;
        fail_count++;
        finish_test();
    end
endmodule
